// [rtl/ccpcu_defs.svh]
// Register offsets, field positions, reset values and timing counts of the compare/PWM unit
`ifndef CCPCU_DEFS_SVH
`define CCPCU_DEFS_SVH

`define CCPCU_ADDR_W        5
`define CCPCU_OFF_IRQ_FLAGS 5'h00
`define CCPCU_OFF_IRQ_ENAB  5'h01
`define CCPCU_OFF_IRQ_PRIO  5'h02
`define CCPCU_OFF_T1_CTRL   5'h03
`define CCPCU_OFF_T3_CTRL   5'h04
`define CCPCU_OFF_T1_LOW    5'h05
`define CCPCU_OFF_T1_HIGH   5'h06
`define CCPCU_OFF_T3_LOW    5'h07
`define CCPCU_OFF_T3_HIGH   5'h08
`define CCPCU_OFF_CH1_LOW   5'h09
`define CCPCU_OFF_CH1_HIGH  5'h0A
`define CCPCU_OFF_CH1_CTRL  5'h0B
`define CCPCU_OFF_CH2_LOW   5'h0C
`define CCPCU_OFF_CH2_HIGH  5'h0D
`define CCPCU_OFF_CH2_CTRL  5'h0E
`define CCPCU_OFF_T2_COUNT  5'h0F
`define CCPCU_OFF_T2_PERIOD 5'h10
`define CCPCU_OFF_T2_CTRL   5'h11
`define CCPCU_OFF_T2_STATUS 5'h12

// Channel flag/enable positions (channel index + 1), then masks and timer control bit positions
`define CCPCU_BIT_CH1_IRQ   1
`define CCPCU_BIT_CH2_IRQ   2
`define CCPCU_IRQ_MASK      8'h06
`define CCPCU_CTRL_MASK     8'h3F
`define CCPCU_BIT_T1_ON     0
`define CCPCU_BIT_T3_ON     0
`define CCPCU_BIT_SEL_LO    3
`define CCPCU_BIT_SEL_HI    6
`define CCPCU_BIT_T2_ON     2
`define CCPCU_T2_CTRL_MASK  8'h7F

`define CCPCU_RST_BYTE      8'h00
`define CCPCU_RST_PERIOD    8'hFF
`define CCPCU_PRE_DIV4      4'h3
`define CCPCU_PRE_DIV16     4'hF

`endif

// [rtl/ccpcu_pkg.sv]
// Types shared by the compare/PWM unit
package ccpcu_pkg;

  typedef enum logic [3:0] {
    CCPCU_MODE_OFF    = 4'h0,
    CCPCU_MODE_TOGGLE = 4'h2,
    CCPCU_MODE_SET    = 4'h8,
    CCPCU_MODE_CLEAR  = 4'h9,
    CCPCU_MODE_SWI    = 4'hA,
    CCPCU_MODE_SEVT   = 4'hB
  } ccpcu_mode_e;

  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] dutyLsb;
    logic [3:0] mode;
  } ccpcu_ctrl_s;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wrData;
    logic       wrStb;
    logic       rdStb;
  } ccpcu_bus_s;

endpackage

// [rtl/ccpcu_top.sv]
// Two-channel compare/PWM unit with its timers and a byte register port
`include "ccpcu_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module ccpcu_top #(
  parameter int unsigned TMR_W = 16,
  parameter int unsigned PWM_W = 8
) (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire ccpcu_pkg::ccpcu_bus_s busIn,
  input  wire logic                adcEnabled,
  output logic [7:0]               rdData,
  output logic [1:0]               ccpOut,
  output logic                     irqReq,
  output logic                     adcStart
);
  import ccpcu_pkg::*;

  if (TMR_W != 16 || PWM_W != 8) begin : g_bad_params
    $error("ccpcu_top supports only 16-bit compare timers and an 8-bit PWM timer");
  end

  // Register write decode
  wire logic wrFlags  = busIn.wrStb && (busIn.addr == `CCPCU_OFF_IRQ_FLAGS);
  wire logic wrEnab   = busIn.wrStb && (busIn.addr == `CCPCU_OFF_IRQ_ENAB);
  wire logic wrPrio   = busIn.wrStb && (busIn.addr == `CCPCU_OFF_IRQ_PRIO);
  wire logic wrT1Ctrl = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T1_CTRL);
  wire logic wrT3Ctrl = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T3_CTRL);
  wire logic wrT1Low  = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T1_LOW);
  wire logic wrT1High = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T1_HIGH);
  wire logic wrT3Low  = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T3_LOW);
  wire logic wrT3High = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T3_HIGH);
  wire logic wrT2Cnt  = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T2_COUNT);
  wire logic wrT2Per  = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T2_PERIOD);
  wire logic wrT2Ctrl = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T2_CTRL);
  wire logic wrT2Stat = busIn.wrStb && (busIn.addr == `CCPCU_OFF_T2_STATUS);

  wire logic [1:0] wrChLow;
  wire logic [1:0] wrChHigh;
  wire logic [1:0] wrChCtrl;
  assign wrChLow  = {busIn.wrStb && (busIn.addr == `CCPCU_OFF_CH2_LOW),
                     busIn.wrStb && (busIn.addr == `CCPCU_OFF_CH1_LOW)};
  assign wrChHigh = {busIn.wrStb && (busIn.addr == `CCPCU_OFF_CH2_HIGH),
                     busIn.wrStb && (busIn.addr == `CCPCU_OFF_CH1_HIGH)};
  assign wrChCtrl = {busIn.wrStb && (busIn.addr == `CCPCU_OFF_CH2_CTRL),
                     busIn.wrStb && (busIn.addr == `CCPCU_OFF_CH1_CTRL)};

  // Software-visible registers and registered outputs
  logic [7:0]       irqFlags_q;
  logic [7:0]       irqEnab_q;
  logic [7:0]       irqPrio_q;
  logic [7:0]       t1Ctrl_q;
  logic [7:0]       t3Ctrl_q;
  logic [TMR_W-1:0] t1Count_q;
  logic [TMR_W-1:0] t3Count_q;
  logic [PWM_W-1:0] t2Count_q;
  logic [PWM_W-1:0] t2Period_q;
  logic [7:0]       t2Ctrl_q;
  logic             t2Flag_q;
  logic [7:0]       rdData_q;
  logic             irqReq_q;
  logic             adcStart_q;

  // Per-channel views, all but chUsesT3 driven from the generate blocks
  wire logic [7:0]  chLow    [2];
  wire logic [7:0]  chHigh   [2];
  wire ccpcu_ctrl_s chCtrl   [2];
  wire logic [1:0]  chMatch;
  wire logic [1:0]  chSevt;
  wire logic [1:0]  chUsesT3;
  wire logic [1:0]  chPin;

  // Time base selection per channel
  wire logic selLo = t3Ctrl_q[`CCPCU_BIT_SEL_LO];
  wire logic selHi = t3Ctrl_q[`CCPCU_BIT_SEL_HI];
  assign chUsesT3 = {selHi | selLo, selHi};

  // Special event triggers reset whichever pair the triggering channel uses
  wire logic t1Reset = |(chSevt & ~chUsesT3);
  wire logic t3Reset = |(chSevt & chUsesT3);
  wire logic t1On    = t1Ctrl_q[`CCPCU_BIT_T1_ON];
  wire logic t3On    = t3Ctrl_q[`CCPCU_BIT_T3_ON];

  // Compare timers: trigger reset beats a byte write, which beats counting
  wire logic [TMR_W-1:0] t1Next = wrT1Low  ? {t1Count_q[15:8], busIn.wrData} :
                                  wrT1High ? {busIn.wrData, t1Count_q[7:0]} :
                                  t1On     ? t1Count_q + 16'h0001 : t1Count_q;
  wire logic [TMR_W-1:0] t3Next = wrT3Low  ? {t3Count_q[15:8], busIn.wrData} :
                                  wrT3High ? {busIn.wrData, t3Count_q[7:0]} :
                                  t3On     ? t3Count_q + 16'h0001 : t3Count_q;

  // PWM timer prescaler and two low-order bits that extend the count
  logic [3:0] t2Pre_q;
  logic [1:0] t2Fine_q;
  logic [3:0] t2Post_q;
  wire logic       t2On    = t2Ctrl_q[`CCPCU_BIT_T2_ON];
  wire logic [3:0] preLast = (t2Ctrl_q[1:0] == 2'h0) ? 4'h0 :
                             (t2Ctrl_q[1:0] == 2'h1) ? `CCPCU_PRE_DIV4 : `CCPCU_PRE_DIV16;
  wire logic       fineTick   = t2On && (t2Pre_q == preLast);
  wire logic       incTick    = fineTick && (t2Fine_q == 2'h3);
  wire logic       periodTick = incTick && (t2Count_q == t2Period_q);
  wire logic [3:0] postLast   = t2Ctrl_q[6:3];
  wire logic       postDone   = periodTick && (t2Post_q == postLast);
  // Compare against the coming fine count so the registered pin falls on time, not one clock late
  wire logic [9:0] t2FineNext = {t2Count_q, t2Fine_q} + 10'h001;

  // Flag set from compare matches
  wire logic [7:0] flagSet = {5'h00, chMatch, 1'b0};

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      t1Count_q <= 16'h0000;
      t3Count_q <= 16'h0000;
    end
    else
    begin
      t1Count_q <= t1Reset ? 16'h0000 : t1Next;
      t3Count_q <= t3Reset ? 16'h0000 : t3Next;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      irqFlags_q <= `CCPCU_RST_BYTE;
      irqEnab_q  <= `CCPCU_RST_BYTE;
      irqPrio_q  <= `CCPCU_RST_BYTE;
      t1Ctrl_q   <= `CCPCU_RST_BYTE;
      t3Ctrl_q   <= `CCPCU_RST_BYTE;
      t2Ctrl_q   <= `CCPCU_RST_BYTE;
    end
    else
    begin
      // A match in the clearing cycle still lands
      irqFlags_q <= ((wrFlags ? busIn.wrData : irqFlags_q) | flagSet) & `CCPCU_IRQ_MASK;
      if (wrEnab)
        irqEnab_q <= busIn.wrData & `CCPCU_IRQ_MASK;
      if (wrPrio)
        irqPrio_q <= busIn.wrData & `CCPCU_IRQ_MASK;
      if (wrT1Ctrl)
        t1Ctrl_q <= busIn.wrData;
      if (wrT3Ctrl)
        t3Ctrl_q <= busIn.wrData;
      if (wrT2Ctrl)
        t2Ctrl_q <= busIn.wrData & `CCPCU_T2_CTRL_MASK;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      t2Pre_q    <= 4'h0;
      t2Fine_q   <= 2'h0;
      t2Count_q  <= 8'h00;
      t2Period_q <= `CCPCU_RST_PERIOD;
      t2Post_q   <= 4'h0;
      t2Flag_q   <= 1'b0;
    end
    else
    begin
      t2Pre_q  <= (!t2On || fineTick) ? 4'h0 : t2Pre_q + 4'h1;
      t2Fine_q <= fineTick ? t2Fine_q + 2'h1 : t2Fine_q;
      if (wrT2Cnt)
        t2Count_q <= busIn.wrData;
      else if (periodTick)
        t2Count_q <= 8'h00;
      else if (incTick)
        t2Count_q <= t2Count_q + 8'h01;
      if (wrT2Per)
        t2Period_q <= busIn.wrData;
      // Postscaler only paces the timer flag; PWM period ignores it
      if (periodTick)
        t2Post_q <= postDone ? 4'h0 : t2Post_q + 4'h1;
      t2Flag_q <= postDone | (wrT2Stat ? busIn.wrData[0] : t2Flag_q);
    end
  end

  genvar g;
  for (g = 0; g < 2; g++) begin : g_chan
    logic [7:0]  low_q;
    logic [7:0]  high_q;
    ccpcu_ctrl_s ctrl_q;
    logic [1:0]  dutyLat_q;
    logic        pin_q;
    logic        eqPrev_q;

    wire logic [TMR_W-1:0] base    = chUsesT3[g] ? t3Count_q : t1Count_q;
    wire logic             isPwm   = (ctrl_q.mode[3:2] == 2'b11);
    wire logic             isCmp   = (ctrl_q.mode[3:2] == 2'b10) || (ctrl_q.mode == CCPCU_MODE_TOGGLE);
    wire logic             eqNow   = ({high_q, low_q} == base);
    // Fire once per arrival at the value so a stopped timer cannot retrigger
    wire logic             match   = isCmp && eqNow && !eqPrev_q;
    wire logic             ctrlClr = wrChCtrl[g] && (busIn.wrData == 8'h00);
    // Ten-bit duty against timer plus two fine bits
    wire logic [9:0]       dutyNew = {low_q, ctrl_q.dutyLsb};
    wire logic             dutyHit = fineTick && ({high_q, dutyLat_q} == t2FineNext);

    assign chLow[g]   = low_q;
    assign chHigh[g]  = high_q;
    assign chCtrl[g]  = ctrl_q;
    assign chMatch[g] = match;
    assign chSevt[g]  = match && (ctrl_q.mode == CCPCU_MODE_SEVT);
    assign chPin[g]   = pin_q;

    always_ff @(posedge mclk)
    begin
      if (!resetn)
      begin
        low_q     <= `CCPCU_RST_BYTE;
        high_q    <= `CCPCU_RST_BYTE;
        ctrl_q    <= ccpcu_ctrl_s'(`CCPCU_RST_BYTE);
        dutyLat_q <= 2'h0;
        eqPrev_q  <= 1'b0;
      end
      else
      begin
        eqPrev_q <= eqNow;
        if (wrChLow[g])
          low_q <= busIn.wrData;
        // Duty buffer is read-only while in PWM mode
        if (isPwm && periodTick)
        begin
          high_q    <= low_q;
          dutyLat_q <= ctrl_q.dutyLsb;
        end
        else if (wrChHigh[g] && !isPwm)
          high_q <= busIn.wrData;
        if (wrChCtrl[g])
          ctrl_q <= ccpcu_ctrl_s'(busIn.wrData & `CCPCU_CTRL_MASK);
      end
    end

    always_ff @(posedge mclk)
    begin
      if (!resetn)
        pin_q <= 1'b0;
      else if (ctrlClr)
        pin_q <= 1'b0;
      else if (isPwm)
      begin
        if (periodTick)
          pin_q <= (dutyNew != 10'h000);
        else if (dutyHit)
          pin_q <= 1'b0;
      end
      else if (match)
      begin
        unique case (ctrl_q.mode)
          CCPCU_MODE_SET:    pin_q <= 1'b1;
          CCPCU_MODE_CLEAR:  pin_q <= 1'b0;
          CCPCU_MODE_TOGGLE: pin_q <= ~pin_q;
          default:           pin_q <= pin_q;
        endcase
      end
    end
  end

  // Read selection; unmapped offsets read zero
  wire logic [7:0] rdMux =
    (busIn.addr == `CCPCU_OFF_IRQ_FLAGS) ? irqFlags_q :
    (busIn.addr == `CCPCU_OFF_IRQ_ENAB)  ? irqEnab_q :
    (busIn.addr == `CCPCU_OFF_IRQ_PRIO)  ? irqPrio_q :
    (busIn.addr == `CCPCU_OFF_T1_CTRL)   ? t1Ctrl_q :
    (busIn.addr == `CCPCU_OFF_T3_CTRL)   ? t3Ctrl_q :
    (busIn.addr == `CCPCU_OFF_T1_LOW)    ? t1Count_q[7:0] :
    (busIn.addr == `CCPCU_OFF_T1_HIGH)   ? t1Count_q[15:8] :
    (busIn.addr == `CCPCU_OFF_T3_LOW)    ? t3Count_q[7:0] :
    (busIn.addr == `CCPCU_OFF_T3_HIGH)   ? t3Count_q[15:8] :
    (busIn.addr == `CCPCU_OFF_CH1_LOW)   ? chLow[0] :
    (busIn.addr == `CCPCU_OFF_CH1_HIGH)  ? chHigh[0] :
    (busIn.addr == `CCPCU_OFF_CH1_CTRL)  ? 8'(chCtrl[0]) :
    (busIn.addr == `CCPCU_OFF_CH2_LOW)   ? chLow[1] :
    (busIn.addr == `CCPCU_OFF_CH2_HIGH)  ? chHigh[1] :
    (busIn.addr == `CCPCU_OFF_CH2_CTRL)  ? 8'(chCtrl[1]) :
    (busIn.addr == `CCPCU_OFF_T2_COUNT)  ? t2Count_q :
    (busIn.addr == `CCPCU_OFF_T2_PERIOD) ? t2Period_q :
    (busIn.addr == `CCPCU_OFF_T2_CTRL)   ? t2Ctrl_q :
    (busIn.addr == `CCPCU_OFF_T2_STATUS) ? {7'h00, t2Flag_q} : 8'h00;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rdData_q   <= 8'h00;
      irqReq_q   <= 1'b0;
      adcStart_q <= 1'b0;
    end
    else
    begin
      rdData_q   <= busIn.rdStb ? rdMux : 8'h00;
      irqReq_q   <= |(irqFlags_q & irqEnab_q);
      // Only the second channel may start a conversion
      adcStart_q <= chSevt[1] && adcEnabled;
    end
  end

  assign rdData   = rdData_q;
  assign ccpOut   = chPin;
  assign irqReq   = irqReq_q;
  assign adcStart = adcStart_q;

endmodule // ccpcu_top

`default_nettype wire

// [tb/ccpcu_checker.sv]
// Port-level assertions for the compare/PWM unit
`include "ccpcu_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module ccpcu_checker (
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire ccpcu_pkg::ccpcu_bus_s busIn,
  input wire logic                  adcEnabled,
  input wire logic [7:0]            rdData,
  input wire logic [1:0]            ccpOut,
  input wire logic                  irqReq,
  input wire logic                  adcStart
);
  import ccpcu_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic isWr  = busIn.wrStb && busIn.wrData == 8'h00;
  wire logic rdCtl = busIn.rdStb && (busIn.addr == `CCPCU_OFF_CH1_CTRL || busIn.addr == `CCPCU_OFF_CH2_CTRL);
  wire logic rdFlg = busIn.rdStb && busIn.addr == `CCPCU_OFF_IRQ_FLAGS;
  wire logic clr1  = isWr && busIn.addr == `CCPCU_OFF_CH1_CTRL;
  wire logic clr2  = isWr && busIn.addr == `CCPCU_OFF_CH2_CTRL;
  wire logic enOff = isWr && busIn.addr == `CCPCU_OFF_IRQ_ENAB;
  property p_ctrl_hi; rdCtl |=> rdData[7:6] == 2'b00; endproperty
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control bits 7:6 not zero");
  property p_flag_hi; rdFlg |=> (rdData & ~`CCPCU_IRQ_MASK) == 8'h00; endproperty
  a_flag_hi: assert property (p_flag_hi) else $error("unused flag bits not zero");
  property p_rd_idle; !busIn.rdStb |=> rdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_adc_pulse; adcStart |=> !adcStart; endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("conversion start longer than one cycle");
  property p_adc_gate; adcStart |-> $past(adcEnabled); endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("conversion start with converter off");
  property p_clr1; clr1 |=> !ccpOut[0]; endproperty
  a_clr1: assert property (p_clr1) else $error("first output latch not cleared");
  property p_clr2; clr2 |=> !ccpOut[1]; endproperty
  a_clr2: assert property (p_clr2) else $error("second output latch not cleared");
  property p_irq_off; enOff |=> ##1 !irqReq [*3]; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while enables are zero");
  c_adc: cover property (adcStart);
  c_irq: cover property (irqReq);
  c_pwm: cover property ($rose(ccpOut[1]));
endmodule // ccpcu_checker
bind ccpcu_top ccpcu_checker u_chk (.mclk(mclk), .resetn(resetn), .busIn(busIn), .adcEnabled(adcEnabled),
  .rdData(rdData), .ccpOut(ccpOut), .irqReq(irqReq), .adcStart(adcStart));
`default_nettype wire

// [tb/ccpcu_pwm_load.sv]
// Load on the PWM pin that measures period and high time in clocks
`timescale 1ns/10ps
`default_nettype none
module ccpcu_pwm_load (
  input wire logic mclk,
  input wire logic pin,
  output int       periodLen,
  output int       highLen
);
  int   cnt = 0;
  int   hcnt = 0;
  logic last = 1'b0;
  // Pin is an output of the device; the load only senses it
  always @(posedge mclk)
  begin
    last <= pin;
    cnt  <= (pin && !last) ? 1 : cnt + 1;
    hcnt <= pin ? hcnt + 1 : 0;
    if (pin && !last)
      periodLen <= cnt;
    if (!pin && last)
      highLen <= hcnt;
  end
endmodule // ccpcu_pwm_load
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the compare/PWM unit
`include "ccpcu_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ccpcu_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, adcEnabled = 1'b0, rdPend = 1'b0;
  ccpcu_bus_s busIn = '0;
  logic [7:0] rdData, expQ[$];
  logic [1:0] ccpOut;
  logic irqReq, adcStart, seen;
  int periodLen, highLen, errorCnt = 0, compares = 0, cyc = 0, seed = 35, gap;
  logic [4:0] ta[7] = '{5'h09, 5'h0A, 5'h0C, 5'h0B, 5'h0E, 5'h02, 5'h10};
  logic [7:0] tm[7] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h06, 8'hFF};
  logic [3:0] mt[6] = '{CCPCU_MODE_SET, CCPCU_MODE_SWI, CCPCU_MODE_TOGGLE, CCPCU_MODE_TOGGLE, CCPCU_MODE_CLEAR,
                        CCPCU_MODE_TOGGLE};
  logic mo[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic t3[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  ccpcu_top dut (.mclk(mclk), .resetn(resetn), .busIn(busIn), .adcEnabled(adcEnabled), .rdData(rdData),
    .ccpOut(ccpOut), .irqReq(irqReq), .adcStart(adcStart));
  ccpcu_pwm_load load (.mclk(mclk), .pin(ccpOut[1]), .periodLen(periodLen), .highLen(highLen));
  initial forever #4 mclk = ~mclk;
  task automatic endOfTest();
    if (errorCnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin errorCnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end
  endtask
  task automatic chk1(string n, logic e, logic g);
    compares++;
    if (g !== e) begin errorCnt++; $display("CHECK FAILED %s exp %b got %b", n, e, g); end
  endtask
  task automatic chkI(string n, int e, int g);
    compares++;
    if (g != e) begin errorCnt++; $display("CHECK FAILED %s exp %0d got %0d", n, e, g); end
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge mclk) busIn <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge mclk) busIn.wrStb <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, logic [7:0] e);
    @(posedge mclk) busIn <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    expQ.push_back(e);
    @(posedge mclk) busIn.rdStb <= 1'b0;
  endtask
  // Results are taken in the cycle after the strobe and only there
  always @(posedge mclk)
  begin
    cyc++;
    if (rdPend) chk8("rdData", expQ.pop_front(), rdData);
    rdPend <= busIn.rdStb;
    if (cyc == 20000) begin errorCnt++; endOfTest(); end
  end
  task automatic waitAdc(int n);
    seen = 1'b0;
    gap = 0;
    // Stops at the first pulse so back-to-back calls measure the trigger period
    while (!seen && gap < n)
    begin
      @(posedge mclk);
      gap++;
      seen = (adcStart === 1'b1);
    end
  endtask
  task automatic runCmp(logic [3:0] m, logic s3, logic e);
    wr(5'h03, 8'h00);
    wr(5'h04, s3 ? 8'h40 : 8'h00);
    for (int i = 5; i < 9; i++) wr(i[4:0], 8'h00);
    wr(5'h0B, {4'h0, m});
    wr(5'h09, 8'h10);
    wr(5'h0A, 8'h00);
    wr(s3 ? 5'h04 : 5'h03, s3 ? 8'h41 : 8'h01);
    repeat (30) @(posedge mclk);
    chk1("ccpOut0", e, ccpOut[0]);
  endtask
  initial
  begin
    logic ok;
    logic [7:0] v;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    for (int a = 0; a < 19; a++) rd(a[4:0], a == 16 ? `CCPCU_RST_PERIOD : `CCPCU_RST_BYTE);
    wr(5'h1F, 8'hA5);
    rd(5'h1F, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      v = $random(seed);
      wr(ta[i], v);
      rd(ta[i], v & tm[i]);
    end
    wr(5'h0B, 8'h00);
    wr(5'h0E, 8'h00);
    wr(5'h00, 8'h00);
    wr(5'h01, 8'h06);
    adcEnabled <= 1'b1;
    wr(5'h0D, 8'h00);
    wr(5'h0C, 8'h05);
    wr(5'h0E, 8'h0B);
    wr(5'h03, 8'h01);
    waitAdc(80);
    chk1("adcStart", 1'b1, seen);
    waitAdc(20);
    chkI("trigPeriod", 6, gap);
    @(posedge mclk) chk1("irqReq", 1'b1, irqReq);
    adcEnabled <= 1'b0;
    waitAdc(20);
    chk1("adcOff", 1'b0, seen);
    wr(5'h0E, 8'h00);
    wr(5'h01, 8'h00);
    wr(5'h00, 8'h00);
    adcEnabled <= 1'b1;
    wr(5'h0A, 8'h00);
    wr(5'h09, 8'h03);
    wr(5'h0B, 8'h0B);
    // Timer one has run past the new value; restart it so the match comes soon
    wr(5'h05, 8'h00);
    waitAdc(30);
    chk1("adcCh1", 1'b0, seen);
    rd(5'h00, 8'h02);
    adcEnabled <= 1'b0;
    for (int i = 0; i < 6; i++) runCmp(mt[i], t3[i], mo[i]);
    wr(5'h0B, 8'h00);
    @(posedge mclk) chk1("ccpOut0clr", 1'b0, ccpOut[0]);
    wr(5'h03, 8'h00);
    wr(5'h10, 8'h03);
    wr(5'h0C, 8'h01);
    wr(5'h0E, 8'h1C);
    wr(5'h11, 8'h04);
    repeat (80) @(posedge mclk);
    chkI("pwmPeriod", 16, periodLen);
    chkI("pwmHigh", 5, highLen);
    rd(5'h0D, 8'h01);
    wr(5'h11, 8'h7C);
    repeat (80) @(posedge mclk);
    chkI("pwmPeriodPost", 16, periodLen);
    wr(5'h0C, 8'h10);
    repeat (40) @(posedge mclk);
    ok = 1'b1;
    repeat (40) @(posedge mclk) ok &= ccpOut[1];
    chk1("pwmNoClear", 1'b1, ok);
    wr(5'h0C, 8'h00);
    wr(5'h0E, 8'h0C);
    repeat (40) @(posedge mclk);
    ok = 1'b0;
    repeat (40) @(posedge mclk) ok |= ccpOut[1];
    chk1("pwmZero", 1'b0, ok);
    repeat (3) @(posedge mclk);
    endOfTest();
  end
endmodule // tb
`default_nettype wire
